// File: hdl/vat_pkg.sv
// Constants, types and timing counts for the VL/AT bus cycle controller.
// Assumes one core clock of CLK_MHZ; control pins are synchronised before use, data and request pins are not.
package vat_pkg;
	// ************
	// Clock and timing
	// ************
	localparam int CLK_MHZ = 250;
	localparam int LCLK_MAX_MHZ = 33;
	localparam int AT_BALE_NS = 40;
	localparam int AT_CMD_NS = 180;
	localparam int AT_ZWS_NS = 60;
	localparam int AT_GAP_UNIT_NS = 120;
	localparam int BALE_CYC = (AT_BALE_NS * CLK_MHZ + 999) / 1000;
	localparam int CMD_CYC = (AT_CMD_NS * CLK_MHZ + 999) / 1000;
	localparam int ZWS_CYC = (AT_ZWS_NS * CLK_MHZ + 999) / 1000;
	localparam int GAP_UNIT_CYC = (AT_GAP_UNIT_NS * CLK_MHZ + 999) / 1000;
	localparam logic [1:0] CLAIM_EDGE = 2'h2;
	localparam logic [1:0] TIMEOUT_EDGE = 2'h3;
	// ************
	// Utility bus read ports
	// ************
	localparam logic [15:0] PORT_KBD_DATA = 16'h0060;
	localparam logic [15:0] PORT_KBD_STAT = 16'h0064;
	localparam logic [15:0] PORT_RTC_INDEX = 16'h0070;
	localparam logic [15:0] PORT_RTC_DATA = 16'h0071;
	// ************
	// Synchroniser bit positions
	// ************
	localparam int S_LCLK = 0, S_FRAME = 1, S_LDEV = 2, S_LRDY = 3, S_CHRDY = 4;
	localparam int S_M16 = 5, S_IO_16BIT_SELECT = 6, S_ZWS = 7, S_ROM_CHIP_SELECT_N = 8, S_PDEVSEL = 9;
	localparam int S_LMEM = 10, S_MSTR = 11, S_MMEMR = 12, S_MMEMW = 13, S_NVRAM = 14;
	localparam int SYNC_W = 15;
	localparam logic [SYNC_W-1:0] SYNC_RESET = 15'h7FFE;
	localparam int FIFO_DEPTH = 8;
	localparam int DATA_W = 32;
	typedef enum logic [3:0] {
		ST_IDLE, ST_LCLK_WAIT, ST_VL_DATA, ST_AT_STATUS, ST_AT_CMD, ST_AT_GAP, ST_DONE, ST_MASTER
	} vat_state_t;
endpackage

// File: hdl/vat_lane_if.sv
// Byte lane steering signals between the cycle engine and the steering logic.
// Assumes the engine drives pending lanes and the steering answers combinationally.
`timescale 1ns/1ps
interface vat_lane_if;
	logic [3:0] pending;
	logic wide;
	logic [31:0] wdata;
	logic [15:0] sd_rd;
	logic [31:0] rold;
	logic [3:0] take;
	logic [1:0] a_lo;
	logic sbhe_n;
	logic [15:0] sd_wr;
	logic [31:0] rnew;
	modport eng(output pending, wide, wdata, sd_rd, rold, input take, a_lo, sbhe_n, sd_wr, rnew);
	modport stg(input pending, wide, wdata, sd_rd, rold, output take, a_lo, sbhe_n, sd_wr, rnew);
endinterface

// File: hdl/vat_steer.sv
// Steering of 32-bit byte lanes onto an 8 or 16 bit AT data bus.
// Assumes pending holds at least one lane while a transfer is in progress.
`timescale 1ns/1ps
module vat_steer (
	vat_lane_if.stg lane
);
	logic [1:0] first;
	logic pair;

	always_comb begin
		first = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (lane.pending[i]) begin
				first = 2'(i);
			end
		end
		pair = lane.wide && !first[0] && lane.pending[first | 2'h1];
		lane.take = (4'h1 << first) | (pair ? (4'h2 << first) : 4'h0);
		lane.a_lo = pair ? {first[1], 1'b0} : first;
		// Odd byte on a narrow device is swapped onto the low lane
		lane.sbhe_n = !(pair || (lane.wide && first[0]));
		lane.sd_wr = {lane.wdata[8*(first | 2'h1) +: 8],
			lane.wdata[8*((lane.wide ? (first & 2'h2) : first)) +: 8]};
	end

	genvar k;
	generate
		for (k = 0; k < 4; k++) begin : g_lane
			assign lane.rnew[8*k +: 8] = !lane.take[k] ? lane.rold[8*k +: 8] :
				((lane.wide && (k % 2 == 1)) ? lane.sd_rd[15:8] : lane.sd_rd[7:0]);
		end
	endgenerate
endmodule

// File: hdl/vat_fifo.sv
// Word FIFO with valid/ready on both sides.
// Assumes a single clock; full and empty are exact.
`timescale 1ns/1ps
module vat_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// Fill side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// Drain side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] count;
	} vat_fifo_t;
	vat_fifo_t st, next_st;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;

	assign in_ready_out = (st.count != (AW+1)'(DEPTH));
	assign out_valid_out = (st.count != '0);
	assign out_data_out = mem[st.rd];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	always_comb begin
		next_st = st;
		if (push) begin
			next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
		end
		if (pop) begin
			next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
		end
		next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
		if (push) begin
			mem[st.wr] <= in_data_in;
		end
	end
endmodule

// File: hdl/vat_top.sv
// VL/AT bus cycle controller: offers cycles not claimed by local memory to a VL slave, else runs AT cycles unless another PCI target claims them.
// Assumes upstream presents decoded cycle info with frame; all pins are asynchronous.
`timescale 1ns/1ps
module vat_top
	import vat_pkg::*;
(
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// Upstream cycle request
	input wire logic frame_n_in,
	input wire logic lmem_n_in,
	input wire logic pci_devsel_n_in,
	input wire logic [31:0] ad_in,
	input wire logic [3:0] cbe_n_in,
	input wire logic a2_in,
	input wire logic is_io_in,
	input wire logic is_write_in,
	input wire logic isa_master_in,
	input wire logic vl_enable_in,
	input wire logic [1:0] isa_gap_in,
	output logic devsel_n_out,
	output logic cpu_burst_ready_n_out,
	// Upstream read data
	output logic [31:0] ad_out,
	output logic ad_valid_out,
	input wire logic ad_ready_in,
	// Local bus
	input wire logic lclk_in,
	output logic lads_n_out,
	output logic lwrite_out,
	input wire logic ldev_n_in,
	input wire logic lrdy_n_in,
	input wire logic [31:0] memory_data_bus_in,
	output logic [31:0] memory_data_bus_out,
	output logic memory_data_bus_oe_n_out,
	// AT bus
	output logic bale_out,
	output logic [15:0] at_addr_out,
	output logic sbhe_n_out,
	output logic memr_n_out,
	output logic memw_n_out,
	output logic ior_n_out,
	output logic iow_n_out,
	input wire logic mem_16bit_select_n_in,
	input wire logic io_16bit_select_n_in,
	input wire logic zero_wait_request_n_in,
	input wire logic iochrdy_in,
	output logic iochrdy_out,
	output logic iochrdy_oe_n_out,
	input wire logic [15:0] sd_in,
	output logic [15:0] sd_out,
	output logic sd_oe_n_out,
	// AT master and DMA to system memory
	input wire logic master_sysmem_n_in,
	input wire logic master_memr_n_in,
	input wire logic master_memw_n_in,
	input wire logic master_a1_in,
	// Utility bus
	input wire logic rom_chip_select_n_in,
	input wire logic nvram_read_n_in,
	output logic utility_bus_direction_out
);
	typedef struct packed {
		vat_state_t state;
		logic [SYNC_W-1:0] sync1;
		logic [SYNC_W-1:0] sync2;
		logic lclk_d;
		logic frame_d;
		logic [1:0] edges;
		logic [7:0] cnt;
		logic io;
		logic wr;
		logic at_master;
		logic [15:0] addr;
		logic [3:0] pending;
		logic wide;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic devsel_n;
		logic cpu_burst_ready_n_n;
		logic lads_n;
		logic lwrite;
		logic [31:0] md_out;
		logic md_oe_n;
		logic bale;
		logic [15:0] at_addr;
		logic sbhe_n;
		logic memr_n, memw_n, ior_n, iow_n;
		logic chrdy_oe_n;
		logic [15:0] sd_out;
		logic sd_oe_n;
		logic utility_bus_direction;
		logic [31:0] ad_data;
		logic ad_valid;
	} vat_state_s_t;
	vat_state_s_t st, next_st;

	vat_lane_if lane();
	logic fifo_in_ready, fifo_out_valid, fifo_pop, push_rd;
	logic [31:0] fifo_out_data;
	logic lclk_rise, frame_fall, cmd_end, utility_read;
	logic [15:0] io_port;
	logic [7:0] gap_cycles;

	// ************
	// Steering and read buffer
	// ************
	assign lane.pending = st.pending;
	assign lane.wide = st.wide;
	assign lane.wdata = st.wdata;
	assign lane.sd_rd = sd_in;
	assign lane.rold = st.rdata;
	vat_steer u_steer (
		.lane(lane)
	);

	// Read data stalls the engine in ST_DONE until the buffer has room
	assign push_rd = (st.state == ST_DONE) && !st.wr;
	assign fifo_pop = fifo_out_valid && (!st.ad_valid || ad_ready_in);
	vat_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.in_valid_in(push_rd),
		.in_ready_out(fifo_in_ready),
		.in_data_in(st.rdata),
		.out_valid_out(fifo_out_valid),
		.out_ready_in(fifo_pop),
		.out_data_out(fifo_out_data)
	);

	// ************
	// Sampled pin events
	// ************
	// local clock edges found
	assign lclk_rise = st.sync2[S_LCLK] && !st.lclk_d;
	assign frame_fall = !st.sync2[S_FRAME] && st.frame_d;
	assign cmd_end = (!st.sync2[S_ZWS] && st.cnt >= 8'(ZWS_CYC - 1)) ||
		(st.sync2[S_CHRDY] && st.cnt >= 8'(CMD_CYC - 1));
	assign gap_cycles = 8'((int'(isa_gap_in) + 1) * GAP_UNIT_CYC);
	assign io_port = st.at_addr;
	assign utility_read = (!st.sync2[S_ROM_CHIP_SELECT_N] && (!st.memr_n || !st.sync2[S_MMEMR])) ||
		(!st.ior_n && (io_port == PORT_KBD_DATA || io_port == PORT_KBD_STAT ||
		io_port == PORT_RTC_INDEX || io_port == PORT_RTC_DATA)) || !st.sync2[S_NVRAM];

	// ************
	// Cycle engine
	// ************
	always_comb begin
		next_st = st;
		next_st.sync1 = {!nvram_read_n_in ? 1'b0 : 1'b1, master_memw_n_in, master_memr_n_in,
			master_sysmem_n_in, lmem_n_in, pci_devsel_n_in, rom_chip_select_n_in,
			zero_wait_request_n_in, io_16bit_select_n_in, mem_16bit_select_n_in,
			iochrdy_in, lrdy_n_in, ldev_n_in, frame_n_in, lclk_in};
		next_st.sync2 = st.sync1;
		next_st.lclk_d = st.sync2[S_LCLK];
		next_st.frame_d = st.sync2[S_FRAME];
		next_st.cpu_burst_ready_n_n = 1'b1;
		next_st.utility_bus_direction = !utility_read;
		if (fifo_pop) begin
			next_st.ad_data = fifo_out_data;
			next_st.ad_valid = 1'b1;
		end else if (ad_ready_in) begin
			next_st.ad_valid = 1'b0;
		end
		case (st.state)
			ST_IDLE: begin
				next_st.edges = 2'h0;
				if (frame_fall && st.sync2[S_LMEM]) begin
					next_st.addr = ad_in[15:0];
					next_st.io = is_io_in;
					next_st.wr = is_write_in;
					next_st.at_master = isa_master_in;
					next_st.pending = ~cbe_n_in;
					next_st.rdata = 32'h0;
					next_st.chrdy_oe_n = !isa_master_in;
					next_st.state = ST_LCLK_WAIT;
				end else if (!st.sync2[S_MSTR]) begin
					next_st.state = ST_MASTER;
				end
			end
			ST_LCLK_WAIT: begin
				if (lclk_rise) begin
					next_st.edges = st.edges + 2'h1;
					if (st.edges == 2'h0) begin
						next_st.wdata = ad_in;
						next_st.lwrite = st.wr;
						next_st.lads_n = !vl_enable_in;
					end else if (st.edges + 2'h1 == CLAIM_EDGE) begin
						next_st.lads_n = 1'b1;
						if (vl_enable_in && !st.sync2[S_LDEV]) begin
							next_st.devsel_n = 1'b0;
							// write data on upper memory data
							next_st.md_out = st.wdata;
							next_st.md_oe_n = !st.wr;
							next_st.state = ST_VL_DATA;
						end
					end else if (st.edges + 2'h1 == TIMEOUT_EDGE) begin
						if (!st.sync2[S_PDEVSEL]) begin
							next_st.chrdy_oe_n = 1'b1;
							next_st.state = ST_IDLE;
						end else begin
							next_st.cnt = 8'h0;
							// Raised on entry so BALE spans the whole status state
							next_st.bale = 1'b1;
							next_st.state = ST_AT_STATUS;
						end
					end
				end
			end
			ST_VL_DATA: begin
				if (lclk_rise && !st.sync2[S_LRDY]) begin
					// read data from upper memory data
					next_st.rdata = memory_data_bus_in;
					next_st.md_oe_n = 1'b1;
					next_st.devsel_n = 1'b1;
					next_st.state = ST_DONE;
				end
			end
			ST_AT_STATUS: begin
				// lane, A2 and low address steering
				next_st.bale = 1'b1;
				next_st.wide = 1'b1;
				next_st.at_addr = {st.addr[15:3], a2_in, lane.a_lo};
				next_st.sbhe_n = lane.sbhe_n;
				next_st.cnt = st.cnt + 8'h1;
				if (st.cnt >= 8'(BALE_CYC - 1)) begin
					next_st.bale = 1'b0;
					next_st.wide = st.io ? 1'b0 : !st.sync2[S_M16];
					next_st.memr_n = st.io || st.wr;
					next_st.memw_n = st.io || !st.wr;
					next_st.ior_n = !st.io || st.wr;
					next_st.iow_n = !st.io || !st.wr;
					next_st.cnt = 8'h0;
					next_st.state = ST_AT_CMD;
				end
			end
			ST_AT_CMD: begin
				if (st.io && !st.sync2[S_IO_16BIT_SELECT]) begin
					next_st.wide = 1'b1;
				end
				// write data steered to AT bus
				next_st.sd_out = lane.sd_wr;
				next_st.sd_oe_n = !st.wr;
				next_st.cnt = st.cnt + 8'h1;
				if (cmd_end) begin
					next_st.rdata = lane.rnew;
					next_st.pending = st.pending & ~lane.take;
					next_st.memr_n = 1'b1;
					next_st.memw_n = 1'b1;
					next_st.ior_n = 1'b1;
					next_st.iow_n = 1'b1;
					next_st.sd_oe_n = 1'b1;
					next_st.cnt = 8'h0;
					next_st.state = ST_AT_GAP;
				end
			end
			ST_AT_GAP: begin
				next_st.cnt = st.cnt + 8'h1;
				if (st.cnt >= gap_cycles - 8'h1) begin
					next_st.cnt = 8'h0;
					next_st.bale = (st.pending != 4'h0);
					next_st.state = (st.pending == 4'h0) ? ST_DONE : ST_AT_STATUS;
				end
			end
			ST_DONE: begin
				if (st.wr || fifo_in_ready) begin
					next_st.cpu_burst_ready_n_n = st.at_master;
					next_st.chrdy_oe_n = 1'b1;
					next_st.state = ST_IDLE;
				end
			end
			ST_MASTER: begin
				// AT side and memory data routed
				next_st.md_out = {sd_in, sd_in};
				next_st.md_oe_n = st.sync2[S_MMEMW];
				next_st.sd_out = master_a1_in ? memory_data_bus_in[31:16] : memory_data_bus_in[15:0];
				next_st.sd_oe_n = st.sync2[S_MMEMR];
				if (st.sync2[S_MSTR]) begin
					next_st.md_oe_n = 1'b1;
					next_st.sd_oe_n = 1'b1;
					next_st.state = ST_IDLE;
				end
			end
			default: begin
				next_st.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			st <= '0;
			st.state <= ST_IDLE;
			st.sync1 <= SYNC_RESET;
			st.sync2 <= SYNC_RESET;
			st.frame_d <= 1'b1;
			{st.devsel_n, st.cpu_burst_ready_n_n, st.lads_n, st.md_oe_n, st.sbhe_n} <= 5'h1F;
			{st.memr_n, st.memw_n, st.ior_n, st.iow_n} <= 4'hF;
			{st.chrdy_oe_n, st.sd_oe_n, st.utility_bus_direction} <= 3'h7;
		end else begin
			st <= next_st;
		end
	end

	// ************
	// Outputs
	// ************
	assign devsel_n_out = st.devsel_n;
	assign cpu_burst_ready_n_out = st.cpu_burst_ready_n_n;
	assign ad_out = st.ad_data;
	assign ad_valid_out = st.ad_valid;
	assign lads_n_out = st.lads_n;
	assign lwrite_out = st.lwrite;
	assign memory_data_bus_out = st.md_out;
	assign memory_data_bus_oe_n_out = st.md_oe_n;
	assign bale_out = st.bale;
	assign at_addr_out = st.at_addr;
	assign sbhe_n_out = st.sbhe_n;
	assign memr_n_out = st.memr_n;
	assign memw_n_out = st.memw_n;
	assign ior_n_out = st.ior_n;
	assign iow_n_out = st.iow_n;
	// Open-drain: only ever pulls low
	assign iochrdy_out = 1'b0;
	assign iochrdy_oe_n_out = st.chrdy_oe_n;
	assign sd_out = st.sd_out;
	assign sd_oe_n_out = st.sd_oe_n;
	assign utility_bus_direction_out = st.utility_bus_direction;

	// ************
	// Checks
	// ************
	chk_lads_one_lclk: assert property (@(posedge clock_in) disable iff (rst_in)
		$fell(st.lads_n) |-> (st.state == ST_LCLK_WAIT) && (st.edges == 2'h1))
		else $error("local strobe not on first local clock");
	chk_devsel_claim: assert property (@(posedge clock_in) disable iff (rst_in)
		$fell(st.devsel_n) |-> st.state == ST_VL_DATA && st.bale == 1'b0)
		else $error("devsel without claim path");
	chk_no_at_on_claim: assert property (@(posedge clock_in) disable iff (rst_in)
		!st.devsel_n |-> st.memr_n && st.memw_n && st.ior_n && st.iow_n && !st.bale)
		else $error("AT command while local slave claimed");
	chk_bale_before_cmd: assert property (@(posedge clock_in) disable iff (rst_in)
		($fell(st.memr_n) || $fell(st.ior_n) || $fell(st.memw_n) || $fell(st.iow_n))
		|-> $past(st.bale))
		else $error("command without preceding BALE");
	chk_cmd_min_len: assert property (@(posedge clock_in) disable iff (rst_in)
		$fell(st.memr_n) && st.sync2[S_ZWS] |-> !st.memr_n [*3])
		else $error("memory read command too short");
	chk_cpu_burst_ready_n_pulse: assert property (@(posedge clock_in) disable iff (rst_in)
		!st.cpu_burst_ready_n_n |=> st.cpu_burst_ready_n_n && st.state == ST_IDLE)
		else $error("burst ready not a single pulse");
	chk_utility_bus_direction_rest: assert property (@(posedge clock_in) disable iff (rst_in)
		st.state == ST_IDLE && st.sync2[S_ROM_CHIP_SELECT_N] && st.sync2[S_NVRAM] && st.ior_n
		&& st.sync2[S_MMEMR] |=> st.utility_bus_direction)
		else $error("direction not resting high");
	chk_timeout_at: assert property (@(posedge clock_in) disable iff (rst_in)
		$rose(st.bale) |-> $past(st.state) == ST_LCLK_WAIT || $past(st.state) == ST_AT_GAP)
		else $error("AT cycle started without timeout");
	chk_gap_len: assert property (@(posedge clock_in) disable iff (rst_in)
		st.state == ST_AT_GAP && next_st.state != ST_AT_GAP
		|-> st.cnt >= 8'(GAP_UNIT_CYC - 1))
		else $error("ISA gap shorter than one unit");
endmodule

// File: tb/vat_partner.sv
// Far side model: one claiming VL slave and one AT device.
// Assumes the bench resolves shared wires and supplies the local clock.
`timescale 1ns/1ps
module vat_partner #(
	parameter logic [31:0] VL_RDATA = 32'h6B2C91D4
) (
	// Local bus
	input wire logic lclk_in,
	input wire logic lads_n_in,
	input wire logic devsel_n_in,
	input wire logic [31:0] bus_in,
	input wire logic claim_in,
	output logic ldev_n_out,
	output logic lrdy_n_out,
	output logic [31:0] bus_out,
	output logic [31:0] vl_wdata_out,
	// AT bus
	input wire logic clock_in,
	input wire logic [15:0] at_addr_in,
	input wire logic rd_n_in,
	input wire logic wr_n_in,
	input wire logic wide_in,
	input wire logic zws_in,
	input wire logic [7:0] wait_in,
	output logic sel16_n_out,
	output logic zws_n_out,
	output logic rdy_out,
	output logic [15:0] sd_out
);
	logic [7:0] str_cyc = 8'h00;
	logic [15:0] last_sd = 16'h0000;
	logic [15:0] rd_val;
	// ************
	// Local bus slave
	// ************
	initial begin
		ldev_n_out = 1'b1;
		lrdy_n_out = 1'b1;
		bus_out = ~VL_RDATA;
		vl_wdata_out = 32'h0;
		forever begin
			@(negedge lads_n_in);
			if (claim_in) begin
				ldev_n_out = 1'b0;
				repeat (2) @(posedge lclk_in);
				#1;
				lrdy_n_out = 1'b0;
				bus_out = VL_RDATA;
				vl_wdata_out = bus_in;
				// Held until taken; a short pulse could slip past the sampler
				wait (devsel_n_in === 1'b1);
				@(posedge lclk_in);
				#1;
				ldev_n_out = 1'b1;
				lrdy_n_out = 1'b1;
				bus_out = ~VL_RDATA;
			end
		end
	end
	// ************
	// AT device
	// ************
	assign rd_val = {at_addr_in[7:0] ^ 8'hC3, at_addr_in[7:0] ^ 8'h5A};
	assign sel16_n_out = !wide_in;
	assign zws_n_out = !(zws_in && !(rd_n_in && wr_n_in));
	assign rdy_out = (rd_n_in && wr_n_in) || (str_cyc >= wait_in);
	// Released lines show the inverse so a stale value never matches
	assign sd_out = !rd_n_in ? rd_val : ~last_sd;
	always @(posedge clock_in) begin
		str_cyc <= (rd_n_in && wr_n_in) ? 8'h00 : str_cyc + {7'h00, str_cyc != 8'hFF};
		if (!rd_n_in) last_sd <= rd_val;
	end
endmodule

// File: tb/vl_at_bus_cycle_control_tb.sv
// Self-checking bench for the VL/AT cycle controller.
// Assumes package, design and far side model are compiled first.
`timescale 1ns/1ps
module vl_at_bus_cycle_control_tb;
	import vat_pkg::*;
	localparam logic [31:0] VL_RDATA = 32'h6B2C91D4;
	logic clock_in = 1'b0, rst_in = 1'b1, lclk_in = 1'b0, frame_n_in = 1'b1, lmem_n_in = 1'b1;
	logic pci_devsel_n_in = 1'b1, a2_in = 1'b0, is_io_in = 1'b0, is_write_in = 1'b0;
	logic vl_enable_in = 1'b0, ad_ready_in = 1'b0, master_sysmem_n_in = 1'b1;
	logic master_memr_n_in = 1'b1, master_memw_n_in = 1'b1, master_a1_in = 1'b0;
	logic rom_chip_select_n_in = 1'b1, nvram_read_n_in = 1'b1;
	logic claim = 1'b0, wide = 1'b0, zws = 1'b0, mst = 1'b0, isa_master_in = 1'b0;
	logic [31:0] ad_in = 32'h0;
	logic [3:0] cbe_n_in = 4'hF;
	logic [1:0] isa_gap_in = 2'h0;
	logic [7:0] wait_cyc = 8'h00;
	logic [15:0] mst_sd = 16'h0, dev_sd, sd_in, sd_out, at_addr_out, sd_mid, addr_mid;
	logic [31:0] vl_bus, vl_wdata, memory_data_bus_in, memory_data_bus_out, ad_out;
	logic devsel_n_out, cpu_burst_ready_n_out, ad_valid_out, lads_n_out, lwrite_out, ldev_n_in;
	logic lrdy_n_in, memory_data_bus_oe_n_out, bale_out, sbhe_n_out, memr_n_out, memw_n_out;
	logic ior_n_out, iow_n_out, sel16_n, zero_wait_request_n_in, dev_rdy, iochrdy_in;
	logic iochrdy_out, iochrdy_oe_n_out, sd_oe_n_out, utility_bus_direction_out;
	logic strobe, dir_mid, sbhe_mid, lads_seen, devsel_seen, lwr, cpu_burst_ready_n_seen;
	int miscompares = 0, comparisons = 0, bale_run = 0, bale_len = 0, bale_cnt = 0;
	int str_run = 0, str_len = 0, str_cnt = 0, gap_run = 0, gap_len = 0;
	initial forever #2 clock_in = ~clock_in;
	initial begin
		// Phase offset keeps the local clock unrelated to the core clock
		#17;
		forever #62.5 lclk_in = ~lclk_in;
	end
	assign strobe = !(memr_n_out && memw_n_out && ior_n_out && iow_n_out);
	assign sd_in = !sd_oe_n_out ? sd_out : (mst ? mst_sd : dev_sd);
	assign memory_data_bus_in = !memory_data_bus_oe_n_out ? memory_data_bus_out :
		(mst ? 32'h12349ABC : vl_bus);
	assign iochrdy_in = dev_rdy && (iochrdy_oe_n_out || iochrdy_out);
	vat_top dut_u (
		.clock_in, .rst_in, .frame_n_in, .lmem_n_in, .pci_devsel_n_in, .ad_in, .cbe_n_in, .a2_in,
		.is_io_in, .is_write_in, .isa_master_in, .vl_enable_in, .isa_gap_in, .devsel_n_out,
		.cpu_burst_ready_n_out, .ad_out, .ad_valid_out, .ad_ready_in, .lclk_in, .lads_n_out,
		.lwrite_out, .ldev_n_in, .lrdy_n_in, .memory_data_bus_in, .memory_data_bus_out,
		.memory_data_bus_oe_n_out, .bale_out, .at_addr_out, .sbhe_n_out, .memr_n_out,
		.memw_n_out, .ior_n_out, .iow_n_out, .mem_16bit_select_n_in(sel16_n),
		.io_16bit_select_n_in(sel16_n), .zero_wait_request_n_in, .iochrdy_in, .iochrdy_out,
		.iochrdy_oe_n_out, .sd_in, .sd_out, .sd_oe_n_out, .master_sysmem_n_in, .master_memr_n_in,
		.master_memw_n_in, .master_a1_in, .rom_chip_select_n_in, .nvram_read_n_in,
		.utility_bus_direction_out
	);
	vat_partner #(.VL_RDATA(VL_RDATA)) far_u (
		.lclk_in, .lads_n_in(lads_n_out), .devsel_n_in(devsel_n_out), .bus_in(memory_data_bus_in),
		.claim_in(claim), .ldev_n_out(ldev_n_in), .lrdy_n_out(lrdy_n_in), .bus_out(vl_bus),
		.vl_wdata_out(vl_wdata), .clock_in, .at_addr_in(at_addr_out),
		.rd_n_in(memr_n_out && ior_n_out), .wr_n_in(memw_n_out && iow_n_out), .wide_in(wide),
		.zws_in(zws), .wait_in(wait_cyc), .sel16_n_out(sel16_n),
		.zws_n_out(zero_wait_request_n_in), .rdy_out(dev_rdy), .sd_out(dev_sd)
	);
	// ************
	// Bus monitor, on the falling edge where outputs are settled
	// ************
	always @(negedge clock_in) begin
		if (bale_out) begin
			if (bale_run == 0) begin
				bale_cnt++;
				gap_len = gap_run;
			end
			bale_run++;
		end else if (bale_run != 0) begin
			bale_len = bale_run;
			bale_run = 0;
		end
		if (strobe) begin
			if (str_run == 0) str_cnt++;
			str_run++;
			gap_run = 0;
			if (str_run == 10) begin
				dir_mid = utility_bus_direction_out;
				sbhe_mid = sbhe_n_out;
				sd_mid = sd_out;
				addr_mid = at_addr_out;
			end
		end else begin
			if (str_run != 0) str_len = str_run;
			str_run = 0;
			if (!bale_out) gap_run++;
		end
		if (!devsel_n_out) devsel_seen = 1'b1;
		if (!cpu_burst_ready_n_out) cpu_burst_ready_n_seen = 1'b1;
		if (!lads_n_out) begin
			lads_seen = 1'b1;
			lwr = lwrite_out;
		end
	end
	// ************
	// Shared tasks and scenarios
	// ************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic start(input logic [31:0] addr, input logic io, input logic wr,
		input logic [3:0] be_n);
		@(negedge clock_in);
		ad_in = addr;
		is_io_in = io;
		is_write_in = wr;
		cbe_n_in = be_n;
		lads_seen = 1'b0;
		devsel_seen = 1'b0;
		cpu_burst_ready_n_seen = 1'b0;
		bale_cnt = 0;
		str_cnt = 0;
		frame_n_in = 1'b0;
	endtask
	task automatic finish_cyc(input logic rd, input logic [31:0] exp, input logic [31:0] mask);
		int n;
		n = 0;
		while (cpu_burst_ready_n_out !== 1'b0 && n < 5000) begin
			@(negedge clock_in);
			n++;
		end
		chk("burst ready", 1, n < 5000);
		frame_n_in = 1'b1;
		n = 0;
		while (rd && ad_valid_out !== 1'b1 && n < 100) begin
			@(negedge clock_in);
			n++;
		end
		if (rd) chk("read data", exp & mask, ad_out & mask);
		ad_ready_in = rd;
		@(negedge clock_in);
		ad_ready_in = 1'b0;
		repeat (16) @(negedge clock_in);
	endtask
	task automatic t_vl;
		for (int w = 0; w < 2; w++) begin
			claim = 1'b1;
			vl_enable_in = 1'b1;
			start(32'h3C5A0404, 1'b1, w[0], 4'h0);
			finish_cyc(!w[0], VL_RDATA, 32'hFFFFFFFF);
			chk("local strobe", 1, lads_seen);
			chk("local write kind", w, lwr);
			chk("devsel", 1, devsel_seen);
			chk("at cycles", 0, bale_cnt + str_cnt);
			if (w) chk("local write data", 32'h3C5A0404, vl_wdata);
		end
		$display("Test local bus done");
	endtask
	task automatic t_isa_master;
		int n;
		claim = 1'b1;
		isa_master_in = 1'b1;
		start(32'h00000300, 1'b1, 1'b1, 4'hE);
		repeat (8) @(negedge clock_in);
		chk("channel ready hold", 0, iochrdy_oe_n_out);
		n = 0;
		while (iochrdy_oe_n_out !== 1'b1 && n < 5000) begin
			@(negedge clock_in);
			n++;
		end
		chk("channel ready release", 1, n < 5000);
		chk("no burst ready", 0, cpu_burst_ready_n_seen);
		frame_n_in = 1'b1;
		isa_master_in = 1'b0;
		repeat (16) @(negedge clock_in);
		$display("Test bus master completion done");
	endtask
	task automatic t_pci;
		claim = 1'b0;
		pci_devsel_n_in = 1'b0;
		start(32'h00000300, 1'b1, 1'b0, 4'hE);
		repeat (200) @(negedge clock_in);
		chk("local strobe", 1, lads_seen);
		chk("other target claim", 0, devsel_seen + bale_cnt + str_cnt);
		frame_n_in = 1'b1;
		pci_devsel_n_in = 1'b1;
		repeat (16) @(negedge clock_in);
		$display("Test other target done");
	endtask
	task automatic t_io_16bit_select;
		wide = 1'b1;
		wait_cyc = 8'h3C;
		start(32'h00000060, 1'b1, 1'b0, 4'hC);
		finish_cyc(1'b1, 32'h0000A33A, 32'h0000FFFF);
		chk("status length", BALE_CYC, bale_len);
		chk("word strobes", 1, str_cnt);
		chk("ready stretch", 1, str_len > 60);
		chk("byte high enable", 0, sbhe_mid);
		chk("direction in port read", 0, dir_mid);
		chk("direction after", 1, utility_bus_direction_out);
		$display("Test word port read done");
	endtask
	task automatic t_mem8;
		wide = 1'b0;
		wait_cyc = 8'h00;
		zws = 1'b1;
		start(32'h0009C810, 1'b0, 1'b1, 4'hD);
		finish_cyc(1'b0, 32'h0, 32'h0);
		chk("odd byte on low lane", 8'hC8, sd_mid[7:0]);
		// Width is unknown while the address goes out, so an odd byte asserts it
		chk("byte high enable", 0, sbhe_mid);
		chk("odd byte address", 16'hC811, addr_mid);
		chk("zero wait end", 1, str_len >= ZWS_CYC && str_len < CMD_CYC);
		chk("direction in write", 1, dir_mid);
		zws = 1'b0;
		$display("Test byte memory write done");
	endtask
	task automatic t_rom8;
		rom_chip_select_n_in = 1'b0;
		isa_gap_in = 2'h1;
		start(32'h000F0020, 1'b0, 1'b0, 4'hC);
		finish_cyc(1'b1, 32'h00007B7A, 32'h0000FFFF);
		chk("byte strobes", 2, str_cnt);
		chk("gap", 1, gap_len >= 2 * GAP_UNIT_CYC && gap_len <= 2 * GAP_UNIT_CYC + 3);
		chk("direction in rom read", 0, dir_mid);
		rom_chip_select_n_in = 1'b1;
		isa_gap_in = 2'h0;
		$display("Test rom read done");
	endtask
	task automatic t_master;
		mst = 1'b1;
		mst_sd = 16'h4D2B;
		master_sysmem_n_in = 1'b0;
		master_memw_n_in = 1'b0;
		repeat (6) @(negedge clock_in);
		chk("master write path", 32'h4D2B4D2B, memory_data_bus_out);
		chk("memory bus drive", 0, memory_data_bus_oe_n_out);
		master_memw_n_in = 1'b1;
		master_memr_n_in = 1'b0;
		master_a1_in = 1'b1;
		repeat (6) @(negedge clock_in);
		chk("master read path", 16'h1234, sd_out);
		chk("data bus drive", 0, sd_oe_n_out);
		master_memr_n_in = 1'b1;
		master_sysmem_n_in = 1'b1;
		master_a1_in = 1'b0;
		mst = 1'b0;
		$display("Test master path done");
	endtask
	task automatic t_nvram;
		nvram_read_n_in = 1'b0;
		repeat (8) @(negedge clock_in);
		chk("direction in nvram read", 0, utility_bus_direction_out);
		nvram_read_n_in = 1'b1;
		repeat (8) @(negedge clock_in);
		chk("direction released", 1, utility_bus_direction_out);
		$display("Test utility done");
	endtask
	task automatic wrap_up;
		$display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge clock_in);
		rst_in = 1'b0;
		repeat (4) @(negedge clock_in);
		chk("direction at rest", 1, utility_bus_direction_out);
		t_vl();
		t_isa_master();
		t_pci();
		t_io_16bit_select();
		t_mem8();
		t_rom8();
		t_master();
		t_nvram();
		wrap_up();
	end
	initial begin
		// Far beyond the few microseconds the scenarios need
		#40000;
		miscompares++;
		wrap_up();
	end
endmodule
